// ### iopm_map.svh
// Register offsets, field positions, reset values and timing counts
// Assumes: included by the register bank; the package needs none of it
`ifndef IOPM_MAP_SVH
`define IOPM_MAP_SVH

`define IOPM_RID_WR        6'h36
`define IOPM_RID_SET       6'h37
`define IOPM_RID_CLR       6'h38
`define IOPM_IOP_WR        6'h39
`define IOPM_IOP_SET       6'h3A
`define IOPM_IOP_CLR       6'h3B

`define IOPM_SWAP_BIT      1
`define IOPM_UART_LO       2
`define IOPM_PLUS_BIT      4
`define IOPM_MINUS_BIT     5
`define IOPM_USB_LO        6
`define IOPM_IOP_MASK      8'hFE
`define IOPM_IOP_RESET     8'h04

`define IOPM_RID_GO_BIT    4
`define IOPM_RID_DONE_BIT  3
`define IOPM_RID_MASK      8'h70
`define IOPM_RID_RESET     8'h00

`define IOPM_MEAS_TIME_US  10
`define IOPM_CLK_MHZ       10
`define IOPM_MEAS_CYCLES   (`IOPM_MEAS_TIME_US * `IOPM_CLK_MHZ)

`endif

// ### iopm_pkg.sv
// Types shared by the I/O and power register bank
// Assumes: nothing from the map header; the enum codes are set here
package iopm_pkg;

  typedef enum logic [1:0] {
    IOPM_LVL_3V3  = 2'h0,
    IOPM_LVL_3V0  = 2'h1,
    IOPM_LVL_2V75 = 2'h2,
    IOPM_LVL_2V5  = 2'h3
  } iopm_level_t;

  typedef enum logic [2:0] {
    IOPM_RID_0R     = 3'h0,
    IOPM_RID_75R    = 3'h1,
    IOPM_RID_100K   = 3'h2,
    IOPM_RID_200K   = 3'h3,
    IOPM_RID_440K   = 3'h4,
    IOPM_RID_FLOAT  = 3'h5,
    IOPM_RID_ERROR  = 3'h7
  } iopm_rid_t;

  // Immediate register request from the ULPI front end
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } iopm_req_t;

  // Analog controls toward the pads and the regulator
  typedef struct packed {
    logic        data_pin_swap;
    logic        plus_line_detect_pull_en;
    logic        minus_line_detect_pull_en;
    iopm_level_t regulator_level;
  } iopm_ana_t;

endpackage

// ### iopm_regs.sv
// I/O and power management register with ID resistance measurement
// Assumes: a ULPI front end in the ref_clk domain issues immediate
// register requests, and an analog converter returns a code.
// Limitation: the conversion time is a fixed cycle count.
// Bits 6:5 of the conversion register stay writable; software keeps them 0.
`timescale 1ns/1ps
`include "iopm_map.svh"

module iopm_regs
  import iopm_pkg::*;
#(
  parameter int MEAS_CYCLES = `IOPM_MEAS_CYCLES
) (
  input  wire logic      ref_clk,
  input  wire logic      nrst,
  input  wire iopm_req_t req,
  output logic [7:0]     rdata,
  output logic           rhit,
  input  wire logic      uart_mode,
  input  wire logic      serial_transmit_drive_en,
  input  wire iopm_rid_t id_resistance_code_in,
  output logic           id_resistance_measure_run,
  output iopm_ana_t      ana
);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [7:0]  io_power_management;
  logic [7:0]  next_iop;
  logic [7:0]  rid_ctl;
  logic [7:0]  next_rid;
  logic [2:0]  id_resistance_code;
  logic        id_resistance_measure_done;
  logic [15:0] meas_cnt;
  logic        meas_end;
  logic        uart_level_on;
  logic        uart_d;
  logic        iop_sel;
  logic        rid_sel;
  logic [7:0]  rid_view;
  iopm_level_t next_level;

  assign meas_end = id_resistance_measure_run && (meas_cnt == 16'h0001);

  // ----------------------------------------------------------------
  // Address decode shared by the read path and the done flag
  // ----------------------------------------------------------------
  assign iop_sel = (req.addr >= `IOPM_IOP_WR)
                   && (req.addr <= `IOPM_IOP_CLR);
  assign rid_sel = (req.addr >= `IOPM_RID_WR)
                   && (req.addr <= `IOPM_RID_CLR);
  // Bit 7 reads zero only because the write mask never stores it
  assign rid_view = {rid_ctl[7:4], id_resistance_measure_done,
                     id_resistance_code};

  // ----------------------------------------------------------------
  // Alias decode
  // ----------------------------------------------------------------
  // direct, set, clear
  always_comb begin
    next_iop = io_power_management;
    if (req.wr) begin
      unique case (req.addr)
        `IOPM_IOP_WR:  next_iop = req.wdata;
        `IOPM_IOP_SET: next_iop = io_power_management | req.wdata;
        `IOPM_IOP_CLR: next_iop = io_power_management & ~req.wdata;
        default:       next_iop = io_power_management;
      endcase
    end
    next_iop = next_iop & `IOPM_IOP_MASK;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      io_power_management <= `IOPM_IOP_RESET;
    end else begin
      io_power_management <= next_iop;
    end
  end

  // ----------------------------------------------------------------
  // ID resistance measurement control
  // ----------------------------------------------------------------
  // start bit written or set, hardware clear wins at completion
  always_comb begin
    next_rid = rid_ctl;
    if (req.wr) begin
      unique case (req.addr)
        `IOPM_RID_WR:  next_rid = req.wdata;
        `IOPM_RID_SET: next_rid = rid_ctl | req.wdata;
        `IOPM_RID_CLR: next_rid = rid_ctl & ~req.wdata;
        default:       next_rid = rid_ctl;
      endcase
    end
    next_rid = next_rid & `IOPM_RID_MASK;
    if (meas_end) begin
      next_rid[`IOPM_RID_GO_BIT] = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rid_ctl <= `IOPM_RID_RESET;
    end else begin
      rid_ctl <= next_rid;
    end
  end

  // Counter stands in for the converter's settling time
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      id_resistance_measure_run <= 1'b0;
      meas_cnt                  <= 16'h0000;
    end else if (meas_end) begin
      id_resistance_measure_run <= 1'b0;
      meas_cnt                  <= 16'h0000;
    end else if (!id_resistance_measure_run && rid_ctl[`IOPM_RID_GO_BIT]) begin
      id_resistance_measure_run <= 1'b1;
      meas_cnt                  <= MEAS_CYCLES[15:0];
    end else if (id_resistance_measure_run) begin
      meas_cnt <= meas_cnt - 16'h0001;
    end
  end

  // code captured at completion; done flag clears on read
  // but a completion in the read cycle wins
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      id_resistance_code         <= 3'h0;
      id_resistance_measure_done <= 1'b0;
    end else if (meas_end) begin
      id_resistance_code         <= id_resistance_code_in;
      id_resistance_measure_done <= 1'b1;
    end else if (req.rd && rid_sel) begin
      id_resistance_measure_done <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // immediate read answered the next cycle
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= 8'h00;
      rhit  <= 1'b0;
    end else begin
      rhit  <= 1'b0;
      rdata <= 8'h00;
      if (req.rd) begin
        if (iop_sel) begin
          rdata <= io_power_management;
          rhit  <= 1'b1;
        end else if (rid_sel) begin
          rdata <= rid_view;
          rhit  <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Analog controls
  // ----------------------------------------------------------------
  // UART level applied once transmit drive enabled after entry
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      uart_d        <= 1'b0;
      uart_level_on <= 1'b0;
    end else begin
      uart_d <= uart_mode;
      if (!uart_mode) begin
        uart_level_on <= 1'b0;
      end else if (serial_transmit_drive_en) begin
        uart_level_on <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Regulator level selection
  // ----------------------------------------------------------------
  // UART level only after transmit enable was seen
  // the delayed mode keeps the switch back one cycle behind the exit
  always_comb begin
    if (uart_level_on && uart_d) begin
      next_level = iopm_level_t'(io_power_management[`IOPM_UART_LO +: 2]);
    end else begin
      next_level = iopm_level_t'(io_power_management[`IOPM_USB_LO +: 2]);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ana <= '{1'b0, 1'b0, 1'b0, IOPM_LVL_3V3};
    end else begin
      ana.data_pin_swap <= io_power_management[`IOPM_SWAP_BIT];
      ana.plus_line_detect_pull_en <=
        io_power_management[`IOPM_PLUS_BIT] | uart_mode;
      ana.minus_line_detect_pull_en <=
        io_power_management[`IOPM_MINUS_BIT] | uart_mode;
      ana.regulator_level <= next_level;
    end
  end

endmodule

// ### iopm_regs_props.sv
// Checker for the I/O and power register bank
// Assumes: bound to iopm_regs, one clock domain
`timescale 1ns/1ps
module iopm_regs_props
  import iopm_pkg::*;
#(
  parameter int MEAS_CYCLES = 100
) (
  input wire logic       ref_clk,
  input wire logic       nrst,
  input wire iopm_req_t  req,
  input wire logic [7:0] rdata,
  input wire logic       rhit,
  input wire logic       uart_mode,
  input wire logic       serial_transmit_drive_en,
  input wire iopm_rid_t  id_resistance_code_in,
  input wire logic       id_resistance_measure_run,
  input wire iopm_ana_t  ana
);
  // ----
  // Properties
  // ----
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  logic [15:0] run_len;
  wire         hit = req.rd && req.addr >= 6'h36 && req.addr <= 6'h3B;
  // Length of the current measurement, seen when it ends
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) run_len <= 16'h0;
    else run_len <= id_resistance_measure_run ? run_len + 16'h1 : 16'h0;
  end
  property p_rhit; hit |=> rhit; endproperty
  property p_miss; !hit |=> !rhit && rdata == 8'h00; endproperty
  property p_rsv; hit && req.addr >= 6'h39 |=> !rdata[0]; endproperty
  property p_swap;
    req.wr && req.addr == 6'h39 |=>
      ##1 ana.data_pin_swap == $past(req.wdata[1], 2);
  endproperty
  property p_uart;
    uart_mode |=> ana.plus_line_detect_pull_en &&
      ana.minus_line_detect_pull_en;
  endproperty
  property p_set;
    req.wr && req.addr == 6'h3A && req.wdata[4] |=>
      ##1 ana.plus_line_detect_pull_en;
  endproperty
  property p_clr;
    req.wr && req.addr == 6'h3B && req.wdata[5] ##1 !uart_mode |=>
      !ana.minus_line_detect_pull_en;
  endproperty
  property p_run;
    $fell(id_resistance_measure_run) |-> run_len == MEAS_CYCLES;
  endproperty
  a_rhit: assert property (p_rhit) else $error("read lost");
  a_miss: assert property (p_miss) else $error("stray read");
  a_rsv: assert property (p_rsv) else $error("bit0 set");
  a_swap: assert property (p_swap) else $error("swap wrong");
  a_uart: assert property (p_uart) else $error("pull off");
  a_set: assert property (p_set) else $error("set lost");
  a_clr: assert property (p_clr) else $error("clear lost");
  a_run: assert property (p_run) else $error("run length");
  c_read: cover property (hit ##1 rhit);
  c_hold: cover property (uart_mode && !serial_transmit_drive_en);
  c_meas: cover property ($fell(id_resistance_measure_run));
  c_uart: cover property (uart_mode && serial_transmit_drive_en);
endmodule
bind iopm_regs iopm_regs_props #(.MEAS_CYCLES(MEAS_CYCLES)) props_inst (
  .ref_clk(ref_clk), .nrst(nrst), .req(req), .rdata(rdata), .rhit(rhit),
  .uart_mode(uart_mode),
  .serial_transmit_drive_en(serial_transmit_drive_en),
  .id_resistance_code_in(id_resistance_code_in),
  .id_resistance_measure_run(id_resistance_measure_run), .ana(ana));

// ### iopm_conv_model.sv
// Converter model on the far side of the ID measurement port
// Assumes: run comes from iopm_regs, sel is picked by the bench
`timescale 1ns/1ps
module iopm_conv_model
  import iopm_pkg::*;
(
  input  wire logic      ref_clk,
  input  wire logic      nrst,
  input  wire logic      run,
  input  wire iopm_rid_t sel,
  output iopm_rid_t      code
);
  // ----
  // Result
  // ----
  // code while running
  // Toggles when idle so a stale sample cannot match
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) code <= IOPM_RID_ERROR;
    else code <= run ? sel : iopm_rid_t'(~code);
  end
endmodule

// ### phy_io_power_mgmt_regs_bench.sv
// Bench for the I/O and power register bank
// Assumes: iopm_regs with a converter model on its far side
`timescale 1ns/1ps
module phy_io_power_mgmt_regs_bench import iopm_pkg::*;;
  // ----
  // Stimulus and scoreboard
  // ----
  logic        ref_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        uart_mode = 1'b0;
  logic        txe = 1'b0;
  logic        rhit, run;
  iopm_req_t   req = '0;
  iopm_rid_t   code, sel = IOPM_RID_0R;
  iopm_ana_t   ana;
  logic [7:0]  rdata, m, exp_q[$];
  logic [5:0]  a;
  logic [16:0] r = 17'h127B8;
  int          bad_count = 0, n_checks = 0, k, w;
  always #50 ref_clk = ~ref_clk;
  iopm_regs #(.MEAS_CYCLES(4)) iopm_regs_inst (.ref_clk(ref_clk),
    .nrst(nrst), .req(req), .rdata(rdata), .rhit(rhit),
    .uart_mode(uart_mode), .serial_transmit_drive_en(txe),
    .id_resistance_code_in(code), .id_resistance_measure_run(run),
    .ana(ana));
  iopm_conv_model iopm_conv_model_inst (.ref_clk(ref_clk), .nrst(nrst),
    .run(run), .sel(sel), .code(code));
  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  task automatic chk(string nm, logic [7:0] e, logic [7:0] s);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask
  // A read notes its expected byte in d
  task automatic acc(logic w, logic [5:0] a, logic [7:0] d);
    @(posedge ref_clk) req <= '{wr: w, rd: !w, addr: a, wdata: d};
    if (!w && a >= 6'h36 && a <= 6'h3B) exp_q.push_back(d);
    @(posedge ref_clk) req <= '0;
  endtask
  task automatic ana_chk;
    repeat (3) @(negedge ref_clk);
    chk("ana", {3'h0, m[1], m[4] | uart_mode, m[5] | uart_mode,
      uart_mode && txe ? m[3:2] : m[7:6]}, {3'h0, ana});
  endtask
  task automatic conclude;
    if (exp_q.size() != 0) chk("queue", 8'h00, 8'(exp_q.size()));
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(negedge ref_clk) begin
    if (rhit === 1'b1) begin
      if (exp_q.size() == 0) chk("rhit", 8'h00, 8'h01);
      else chk("rdata", exp_q.pop_front(), rdata);
    end
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    bad_count++;
    conclude();
  end
  initial begin
    m = 8'h04;
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    for (k = 0; k < 3; k++)
      acc(1'b0, 6'h39 + 6'(k), 8'h04);
    for (k = 0; k < 12; k++) begin
      r = lfsr(r);
      a = 6'h39 + 6'(r[9:8] % 2'h3);
      acc(1'b1, a, r[7:0]);
      m = (a == 6'h39 ? r[7:0] : a == 6'h3A ? m | r[7:0] : m & ~r[7:0]);
      m = m & 8'hFE;
      acc(1'b0, 6'h39 + 6'(r[11:10] % 2'h3), m);
      ana_chk();
    end
    acc(1'b1, 6'h39, 8'hCA);
    m = 8'hCA;
    // UART entry without transmit enable keeps the USB level
    uart_mode <= 1'b1;
    ana_chk();
    @(posedge ref_clk) txe <= 1'b1;
    ana_chk();
    @(posedge ref_clk) uart_mode <= 1'b0;
    ana_chk();
    acc(1'b1, 6'h3C, 8'hFF);
    acc(1'b0, 6'h3C, 8'h00);
    @(negedge ref_clk) chk("rhit", 8'h00, {7'h0, rhit});
    acc(1'b0, 6'h39, m);
    for (k = 0; k < 8; k++) if (k != 6) begin
      @(posedge ref_clk) sel <= iopm_rid_t'(k);
      // link sequence: start, wait for the end, read the code
      acc(1'b1, k[0] ? 6'h37 : 6'h36, 8'h10);
      for (w = 0; w < 40 && !(w > 2 && run === 1'b0); w++)
        @(negedge ref_clk);
      if (w == 40) begin
        bad_count++;
        break;
      end
      acc(1'b0, 6'h36 + 6'(k % 3), 8'h08 | 8'(k));
    end
    acc(1'b0, 6'h38, 8'h07);
    repeat (2) @(posedge ref_clk);
    conclude();
  end
endmodule
